// file: iafc_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module iafc_bus_model (
    // Clock
    input  wire logic                core_clk_i,
    // Bus events towards the block
    output var iafc_pkg::iafc_event_type evt_o
);
    initial evt_o <= '0;

    // Bus role and frame level, changed just after an edge
    task automatic set_role(input logic slv, input logic mst, input logic frm);
        @(posedge core_clk_i);
        evt_o.slave_mode   <= slv;
        evt_o.master_mode  <= mst;
        evt_o.frame_active <= frm;
    endtask : set_role

    // First frame after a start; the byte is not held once the pulse ends
    task automatic send_addr(input logic [7:0] a);
        @(posedge core_clk_i);
        evt_o.addr_valid <= 1'b1;
        evt_o.addr_byte  <= a;
        @(posedge core_clk_i);
        evt_o.addr_valid <= 1'b0;
        evt_o.addr_byte  <= ~a;
    endtask : send_addr

    // Eighth data clock has gone low
    task automatic eighth_clock;
        @(posedge core_clk_i);
        evt_o.eighth_low <= 1'b1;
        @(posedge core_clk_i);
        evt_o.eighth_low <= 1'b0;
    endtask : eighth_clock
endmodule : iafc_bus_model
`default_nettype wire

// file: iafc_core.sv
// Notes on behaviour
// (R01) Slave, fsx=0: address frame upper seven bits equal to second address selects us.
// (R02) Second address register reachable only while interface enable is 0.
// (R03) Second address: bits 7..1 address reset 0, bit 0 format reset 1.
// (R04) Both format bits 0: two-wire, both addresses and general call enabled.
// (R05) fs=0, fsx=1: primary address and general call only, second ignored.
// (R06) fs=1, fsx=0: second address only; primary and general call ignored.
// (R07) Both format bits 1: synchronous serial, all addresses and general call off.
// (R08) Synchronous format has no address, no acknowledge, master only.
// (R09) Mode register reachable only while interface enable is 1.
// (R10) Mode bit 7 picks LSB-first; software keeps 0 in two-wire format.
// (R11) Wait bit 6 acts only as two-wire master; 0 means no wait.
// (R12) With wait, 8th clock low sets flag and holds clock; clearing releases.
// (R13) Master transfer clock from select bits 5..3 plus divider extension.
// (R14) Interface enable steers shared locations between address and mode/data registers; no data register here, OFF_SHARED_A reads 0 while ie is 1.
// (R15) Software keeps primary format bit 0 when general call is needed.
// (R16) Software sets divider extension above 16 MHz peripheral clock.
// (R17) All enabled addresses and general call compared together, each match reported.
// (R18) Format and clock-select changes applied only between frames.
`timescale 1ns/1ns
`default_nettype none
module iafc_core (
    // Clock and reset
    input  wire logic                    core_clk_i,
    input  wire logic                    resetn_i,
    // APB slave
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [7:0]              paddr_i,
    input  wire logic [31:0]             pwdata_i,
    output logic      [31:0]             prdata_o,
    output logic                         pready_o,
    output logic                         pslverr_o,
    // Shifter and bus-state events
    input  wire iafc_pkg::iafc_event_type evt_i,
    // Results
    output var iafc_pkg::iafc_match_type match_o,
    output logic                         sync_format_o,
    output logic                         lsb_first_o,
    output logic                         scl_hold_o,
    output logic                         tick_o,
    output logic                         irq_o
);

    localparam int ST_W_L = iafc_pkg::ST_W;

    iafc_pkg::iafc_state_type st_reg;
    iafc_pkg::iafc_state_type st_next;

    logic                  setup;
    logic                  access;
    logic                  wr;
    logic                  set_wait;
    logic [ST_W_L-1:0]     st_clr;
    logic [ST_W_L-1:0]     st_set;
    logic [6:0]            rx_adr;
    logic [7:0]            div_last;

    // Zero wait states: the access phase completes while our pready is high
    assign setup  = psel_i && !penable_i;
    assign access = psel_i && penable_i && st_reg.pready;
    assign wr     = access && pwrite_i;
    assign rx_adr = evt_i.addr_byte[iafc_pkg::ADR_HI:iafc_pkg::ADR_LO];
    assign div_last = iafc_pkg::DIV_LAST[{st_reg.app_ext, st_reg.app_cks}];
    // Wait exists only for a two-wire master
    assign set_wait = evt_i.eighth_low && evt_i.master_mode && !st_reg.app_sync
                      && st_reg.mode[iafc_pkg::MODE_WAIT_BIT]; // R11 R12

    always_comb begin
        st_next         = st_reg;
        st_next.pready  = 1'b0;
        st_next.tick    = 1'b0;
        st_next.match   = '0;
        st_clr          = '0;
        st_set          = '0;

        // Bus answer: data is captured in setup, pready raised for one access cycle
        case (st_reg.bus)
            iafc_pkg::BUS_IDLE: begin
                if (setup) begin
                    st_next.bus     = iafc_pkg::BUS_ACK;
                    st_next.pready  = 1'b1;
                    st_next.pslverr = 1'b0;
                    st_next.prdata  = '0;
                    case (paddr_i)
                        iafc_pkg::OFF_CTRL: begin
                            st_next.prdata[iafc_pkg::CTRL_IE_BIT]  = st_reg.ie;
                            st_next.prdata[iafc_pkg::CTRL_EXT_BIT] = st_reg.ext;
                        end
                        iafc_pkg::OFF_SHARED_A: begin
                            if (!st_reg.ie) begin
                                st_next.prdata[7:0] = st_reg.second_slave_address; // R02 R14
                            end
                        end
                        iafc_pkg::OFF_SHARED_B: begin
                            st_next.prdata[7:0] = st_reg.ie ? st_reg.mode : st_reg.primary_slave_address; // R09 R14
                        end
                        iafc_pkg::OFF_STATUS: begin
                            st_next.prdata[ST_W_L-1:0] = st_reg.status;
                        end
                        iafc_pkg::OFF_MASK: begin
                            st_next.prdata[ST_W_L-1:0] = st_reg.mask;
                        end
                        default: begin
                            st_next.pslverr = 1'b1;
                        end
                    endcase
                end
            end
            iafc_pkg::BUS_ACK: begin
                st_next.bus = iafc_pkg::BUS_IDLE;
            end
            default: begin
                st_next.bus = iafc_pkg::BUS_IDLE;
            end
        endcase

        // Writes take effect at the completing access edge
        if (wr) begin
            case (paddr_i)
                iafc_pkg::OFF_CTRL: begin
                    st_next.ie  = pwdata_i[iafc_pkg::CTRL_IE_BIT];
                    st_next.ext = pwdata_i[iafc_pkg::CTRL_EXT_BIT];
                end
                iafc_pkg::OFF_SHARED_A: begin
                    if (!st_reg.ie) begin
                        st_next.second_slave_address = pwdata_i[7:0]; // R02 R03 R14
                    end
                end
                iafc_pkg::OFF_SHARED_B: begin
                    if (st_reg.ie) begin
                        st_next.mode = pwdata_i[7:0]; // R09 R14
                    end else begin
                        st_next.primary_slave_address = pwdata_i[7:0]; // R14
                    end
                end
                iafc_pkg::OFF_STATUS: begin
                    st_clr = pwdata_i[ST_W_L-1:0];
                end
                iafc_pkg::OFF_MASK: begin
                    st_next.mask = pwdata_i[ST_W_L-1:0];
                end
                default: begin
                    st_next.mask = st_reg.mask;
                end
            endcase
        end

        // Format and clock select only move while no frame is shifting
        if (!evt_i.frame_active) begin
            st_next.app_fs   = st_reg.primary_slave_address[iafc_pkg::FMT_BIT]; // R18
            st_next.app_fsx  = st_reg.second_slave_address[iafc_pkg::FMT_BIT]; // R18
            st_next.app_cks  = st_reg.mode[iafc_pkg::MODE_CKS_HI:iafc_pkg::MODE_CKS_LO];
            st_next.app_ext  = st_reg.ext; // R13
            st_next.app_sync = st_next.app_fs && st_next.app_fsx; // R07 R08
        end

        // Address compare, all candidates in parallel
        if (evt_i.addr_valid && evt_i.slave_mode && !st_reg.app_sync) begin
            st_next.match.primary = !st_reg.app_fs
                && rx_adr == st_reg.primary_slave_address[iafc_pkg::ADR_HI:iafc_pkg::ADR_LO]; // R04 R05 R06 R17
            st_next.match.second = !st_reg.app_fsx
                && rx_adr == st_reg.second_slave_address[iafc_pkg::ADR_HI:iafc_pkg::ADR_LO]; // R01 R04 R05 R17
            st_next.match.gcall = !st_reg.app_fs && rx_adr == iafc_pkg::GCALL_ADR; // R06 R17
        end
        st_set[iafc_pkg::ST_ADDR]  = st_next.match.primary || st_next.match.second;
        st_set[iafc_pkg::ST_GCALL] = st_next.match.gcall;
        st_set[iafc_pkg::ST_WAIT]  = set_wait; // R12

        // Sticky status, a new event wins over a clear in the same cycle
        st_next.status    = (st_reg.status & ~st_clr) | st_set;
        st_next.irq       = |(st_next.status & st_next.mask);
        st_next.wait_hold = set_wait
            || (st_reg.wait_hold && st_next.status[iafc_pkg::ST_WAIT]); // R12

        // Transfer-clock divider, one-cycle enable per period in master mode
        if (evt_i.master_mode) begin
            if (st_reg.div_cnt == div_last) begin
                st_next.div_cnt = iafc_pkg::CNT_ZERO;
                st_next.tick    = 1'b1; // R13
            end else begin
                st_next.div_cnt = st_reg.div_cnt + iafc_pkg::CNT_ONE;
            end
        end else begin
            st_next.div_cnt = iafc_pkg::CNT_ZERO;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            st_reg <= iafc_pkg::STATE_RST; // R03
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata_o      = st_reg.prdata;
    assign pready_o      = st_reg.pready;
    assign pslverr_o     = st_reg.pslverr;
    assign match_o       = st_reg.match;
    assign sync_format_o = st_reg.app_sync; // R08
    assign lsb_first_o   = st_reg.mode[iafc_pkg::MODE_ORDER_BIT]; // R10
    assign scl_hold_o    = st_reg.wait_hold;
    assign tick_o        = st_reg.tick;
    assign irq_o         = st_reg.irq;

    // Checks
    second_slave_address_gate_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R02
        wr && paddr_i == iafc_pkg::OFF_SHARED_A && st_reg.ie |=> $stable(st_reg.second_slave_address))
        else $error("second address written while interface enabled");

    mode_gate_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R09
        wr && paddr_i == iafc_pkg::OFF_SHARED_B && !st_reg.ie |=> $stable(st_reg.mode))
        else $error("mode written while interface disabled");

    second_slave_address_reset_a: assert property (@(posedge core_clk_i) // R03
        !resetn_i |=> st_reg.second_slave_address == iafc_pkg::RST_SECOND_SLAVE_ADDRESS)
        else $error("second address reset value wrong");

    second_match_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R01
        evt_i.addr_valid && evt_i.slave_mode && !st_reg.app_fsx
        && rx_adr == st_reg.second_slave_address[iafc_pkg::ADR_HI:iafc_pkg::ADR_LO]
        |=> match_o.second && st_reg.status[iafc_pkg::ST_ADDR])
        else $error("second address match missed");

    primary_match_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R04
        evt_i.addr_valid && evt_i.slave_mode && !st_reg.app_fs
        && rx_adr == st_reg.primary_slave_address[iafc_pkg::ADR_HI:iafc_pkg::ADR_LO] |=> match_o.primary)
        else $error("primary address match missed");

    fsx_off_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R05
        st_reg.app_fsx |=> !match_o.second)
        else $error("second address matched while disabled");

    gcall_off_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R06
        st_reg.app_fs |=> !match_o.gcall && !match_o.primary)
        else $error("primary or general call matched while disabled");

    sync_quiet_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R07
        st_reg.app_fs && st_reg.app_fsx |-> sync_format_o ##1 match_o == '0)
        else $error("match reported in synchronous format");

    wait_set_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R12
        set_wait |=> scl_hold_o && st_reg.status[iafc_pkg::ST_WAIT])
        else $error("wait not entered");

    wait_end_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R12
        $fell(st_reg.status[iafc_pkg::ST_WAIT]) |-> !scl_hold_o)
        else $error("clock still held after flag cleared");

    no_wait_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R11
        evt_i.eighth_low && !st_reg.mode[iafc_pkg::MODE_WAIT_BIT] && !scl_hold_o |=> !scl_hold_o)
        else $error("wait entered with wait disabled");

    frame_freeze_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R18
        evt_i.frame_active |=> $stable({st_reg.app_fs, st_reg.app_fsx, st_reg.app_cks}))
        else $error("format changed during a frame");

    div_tick_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R13
        evt_i.master_mode && st_reg.div_cnt == div_last |=> tick_o ##1 !tick_o)
        else $error("transfer clock enable missed");

    apb_answer_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        setup && st_reg.bus == iafc_pkg::BUS_IDLE |=> pready_o ##1 !pready_o)
        else $error("bus answer timing wrong");

    // Match, status, wait and applied-format checks
    gcall_match_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R17
        evt_i.addr_valid && evt_i.slave_mode && !st_reg.app_fs
        && rx_adr == iafc_pkg::GCALL_ADR |=> match_o.gcall)
        else $error("general call match missed");

    match_sticky_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R17
        st_set[iafc_pkg::ST_ADDR] |=> st_reg.status[iafc_pkg::ST_ADDR])
        else $error("address match flag not set");

    sync_no_wait_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R08
        evt_i.eighth_low && st_reg.app_sync && !scl_hold_o |=> !scl_hold_o)
        else $error("wait entered in synchronous format");

    slave_no_wait_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R11
        evt_i.eighth_low && !evt_i.master_mode && !scl_hold_o |=> !scl_hold_o)
        else $error("wait entered outside master mode");

    wait_irq_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // R12
        set_wait && st_reg.mask[iafc_pkg::ST_WAIT] && !wr |=> irq_o)
        else $error("wait flag raised no interrupt");

    fmt_reset_a: assert property (@(posedge core_clk_i) // R05
        !resetn_i |=> st_reg.app_fsx && !st_reg.app_fs && !sync_format_o)
        else $error("applied format after reset wrong");

    // Main scenarios
    both_match_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        match_o.primary && match_o.second);
    second_hit_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        match_o.second);
    gcall_hit_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        match_o.gcall);
    wait_cycle_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        scl_hold_o ##1 !scl_hold_o);
    sync_mode_c: cover property (@(posedge core_clk_i) disable iff (!resetn_i)
        sync_format_o && tick_o);

endmodule : iafc_core
`default_nettype wire

// file: iafc_pkg.sv
package iafc_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_SHARED_A = 8'h04;
    localparam logic [7:0] OFF_SHARED_B = 8'h08;
    localparam logic [7:0] OFF_STATUS   = 8'h0c;
    localparam logic [7:0] OFF_MASK     = 8'h10;

    // Control register fields
    localparam int CTRL_IE_BIT  = 7;
    localparam int CTRL_EXT_BIT = 0;

    // Slave-address register fields
    localparam int ADR_HI = 7;
    localparam int ADR_LO = 1;
    localparam int FMT_BIT = 0;

    // Mode register fields
    localparam int MODE_ORDER_BIT = 7;
    localparam int MODE_WAIT_BIT  = 6;
    localparam int MODE_CKS_HI    = 5;
    localparam int MODE_CKS_LO    = 3;

    // Status and mask fields
    localparam int ST_W        = 3;
    localparam int ST_WAIT     = 0;
    localparam int ST_ADDR     = 1;
    localparam int ST_GCALL    = 2;

    // Reset values and constants
    localparam logic [7:0] RST_SAR   = 8'h00;
    localparam logic [7:0] RST_SECOND_SLAVE_ADDRESS  = 8'h01;
    localparam logic [7:0] RST_MODE  = 8'h00;
    localparam logic [6:0] GCALL_ADR = 7'h00;
    localparam logic [7:0] CNT_ZERO  = 8'h00;
    localparam logic [7:0] CNT_ONE   = 8'h01;

    // Last count of the transfer-clock divider, indexed by {extension, select}
    localparam logic [7:0] DIV_LAST [16] = '{
        8'h1b, 8'h27, 8'h2f, 8'h3f, 8'h4f, 8'h63, 8'h6f, 8'h7f,
        8'h37, 8'h4f, 8'h5f, 8'h7f, 8'h9f, 8'hc7, 8'hdf, 8'hff
    };

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } iafc_bus_type;

    // Events from the shifter and bus-state logic on the same clock
    typedef struct packed {
        logic       slave_mode;
        logic       master_mode;
        logic       frame_active;
        logic       addr_valid;
        logic [7:0] addr_byte;
        logic       eighth_low;
    } iafc_event_type;

    typedef struct packed {
        logic primary;
        logic second;
        logic gcall;
    } iafc_match_type;

    typedef struct packed {
        iafc_bus_type   bus;
        logic           pready;
        logic           pslverr;
        logic [31:0]    prdata;
        logic           ie;
        logic           ext;
        logic [7:0]     primary_slave_address;
        logic [7:0]     second_slave_address;
        logic [7:0]     mode;
        logic           app_fs;
        logic           app_fsx;
        logic           app_sync;
        logic [2:0]     app_cks;
        logic           app_ext;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic           irq;
        logic           wait_hold;
        logic [7:0]     div_cnt;
        logic           tick;
        iafc_match_type match;
    } iafc_state_type;

    localparam iafc_state_type STATE_RST = '{
        bus: BUS_IDLE, primary_slave_address: RST_SAR, second_slave_address: RST_SECOND_SLAVE_ADDRESS, mode: RST_MODE,
        app_fsx: 1'b1, default: '0
    };

endpackage : iafc_pkg

// file: tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic                     core_clk_i;
    logic                     resetn_i;
    logic                     psel, penable, pwrite, pready, pslverr;
    logic                     sync_fmt, lsb_first, scl_hold, tick, irq;
    logic [7:0]               paddr;
    logic [31:0]              pwdata, prdata;
    iafc_pkg::iafc_event_type evt;
    iafc_pkg::iafc_match_type match;
    int                       error_cnt = 0;
    int                       checks = 0;
    int                       per;
    localparam int DIVS [16] = '{28, 40, 48, 64, 80, 100, 112, 128,
                                 56, 80, 96, 128, 160, 200, 224, 256};

    iafc_core i_iafc_core (
        .core_clk_i    (core_clk_i),
        .resetn_i      (resetn_i),
        .psel_i        (psel),
        .penable_i     (penable),
        .pwrite_i      (pwrite),
        .paddr_i       (paddr),
        .pwdata_i      (pwdata),
        .prdata_o      (prdata),
        .pready_o      (pready),
        .pslverr_o     (pslverr),
        .evt_i         (evt),
        .match_o       (match),
        .sync_format_o (sync_fmt),
        .lsb_first_o   (lsb_first),
        .scl_hold_o    (scl_hold),
        .tick_o        (tick),
        .irq_o         (irq)
    );
    iafc_bus_model i_iafc_bus_model (
        .core_clk_i (core_clk_i),
        .evt_o      (evt)
    );

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // One APB transfer; read data and response taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        int n = 0;
        @(posedge core_clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(pready, 1'b1);
        chk(pslverr, err);
        if (!w) chk(prdata, exp);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, '0, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0, exp, 1'b0);
    endtask : rd

    task automatic settle;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask : settle

    // Edges from the present point to the next tick seen high
    task automatic next_tick(output int n);
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (tick !== 1'b1 && n < 600);
    endtask : next_tick

    initial begin
        repeat (40000) @(posedge core_clk_i);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        resetn_i <= 1'b0;
        psel     <= 1'b0;
        penable  <= 1'b0;
        pwrite   <= 1'b0;
        paddr    <= 8'h00;
        pwdata   <= 32'h0;
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        #1 chk({sync_fmt, scl_hold, irq, tick}, 4'h0);
        rd(8'h00, 32'h00);
        rd(8'h04, 32'h01);
        rd(8'h08, 32'h00);
        apb(1'b0, 8'h14, '0, 32'h0, 1'b1);
        apb(1'b1, 8'h14, 32'hff, '0, 1'b1);
        wr(8'h04, 32'hff);
        rd(8'h04, 32'hff);
        i_iafc_bus_model.set_role(1'b1, 1'b0, 1'b0);
        // Every format code against primary, second and general call
        for (int f = 0; f < 4; f++) begin
            wr(8'h08, {24'h0, 7'h12, f[1]});
            wr(8'h04, {24'h0, 7'h34, f[0]});
            settle();
            chk(sync_fmt, f == 3);
            i_iafc_bus_model.send_addr(8'h25);
            #1 chk(match, {~f[1], 2'b00});
            i_iafc_bus_model.send_addr(8'h68);
            #1 chk(match, {1'b0, ~f[0], 1'b0});
            i_iafc_bus_model.send_addr(8'h00);
            #1 chk(match, {2'b00, ~f[1]});
        end
        wr(8'h00, 32'h80);
        wr(8'h08, 32'h98);
        rd(8'h08, 32'h98);
        #1 chk(lsb_first, 1'b1);
        rd(8'h04, 32'h00);
        wr(8'h04, 32'h55);
        wr(8'h08, 32'h18);
        wr(8'h00, 32'h00);
        rd(8'h04, 32'h69);
        rd(8'h08, 32'h25);
        wr(8'h08, 32'h24);
        wr(8'h04, 32'h24);
        settle();
        i_iafc_bus_model.send_addr(8'h24);
        #1 chk(match, 3'b110);
        rd(8'h0c, 32'h06);
        wr(8'h0c, 32'h06);
        rd(8'h0c, 32'h00);
        // Wait state as master, unmasked then masked, then wait off
        i_iafc_bus_model.set_role(1'b0, 1'b1, 1'b0);
        wr(8'h00, 32'h80);
        wr(8'h08, 32'h40);
        wr(8'h10, 32'h01);
        i_iafc_bus_model.eighth_clock();
        #1 chk({scl_hold, irq}, 2'b11);
        rd(8'h0c, 32'h01);
        #1 chk(scl_hold, 1'b1);
        wr(8'h0c, 32'h01);
        #1 chk({scl_hold, irq}, 2'b00);
        wr(8'h10, 32'h00);
        i_iafc_bus_model.eighth_clock();
        #1 chk({scl_hold, irq}, 2'b10);
        wr(8'h0c, 32'h01);
        wr(8'h08, 32'h00);
        i_iafc_bus_model.eighth_clock();
        #1 chk(scl_hold, 1'b0);
        // Divider period for every select code, extension off then on
        for (int i = 0; i < 16; i++) begin
            wr(8'h00, 32'h80 + i / 8);
            wr(8'h08, (i % 8) * 8);
            next_tick(per);
            next_tick(per);
            next_tick(per);
            chk(per, DIVS[i]);
        end
        // Format change held off until the frame ends
        wr(8'h00, 32'h00);
        i_iafc_bus_model.set_role(1'b1, 1'b0, 1'b1);
        wr(8'h08, 32'h25);
        wr(8'h04, 32'h25);
        settle();
        chk(sync_fmt, 1'b0);
        i_iafc_bus_model.set_role(1'b1, 1'b0, 1'b0);
        settle();
        chk(sync_fmt, 1'b1);
        // Synchronous format as master: divider runs, no wait state
        wr(8'h00, 32'h80);
        wr(8'h08, 32'h40);
        i_iafc_bus_model.set_role(1'b0, 1'b1, 1'b0);
        next_tick(per);
        chk(sync_fmt, 1'b1);
        i_iafc_bus_model.eighth_clock();
        #1 chk({scl_hold, irq}, 2'b00);
        rd(8'h0c, 32'h00);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
